// *** rtl/hw_mode_pkg.sv ***
package hw_mode_pkg;

    // Source encodings
    localparam logic       DAC_SEL_SPDIF      = 1'b0;
    localparam logic       DAC_SEL_PRIMARY    = 1'b1;
    localparam logic       PTX_SRC_SPDIF      = 1'b0;
    localparam logic       PTX_SRC_ADC        = 1'b1;
    localparam logic [1:0] STX_SRC_SPDIF      = 2'h0;
    localparam logic [1:0] STX_SRC_ADC        = 2'h1;
    localparam logic [1:0] STX_SRC_NONE       = 2'h2;
    localparam logic [1:0] STX_SRC_PRIMARY    = 2'h3;

    // Primary port format codes
    localparam logic [1:0] FMT_RJ24           = 2'h0;
    localparam logic [1:0] FMT_RJ20           = 2'h1;
    localparam logic [1:0] FMT_LJ24           = 2'h2;
    localparam logic [1:0] FMT_I2S24          = 2'h3;

    // Fixed clock ratios in hardware mode
    localparam logic [9:0] MCLK_RATIO_FS      = 10'h100;
    localparam logic [6:0] BCLK_PER_FRAME     = 7'h40;

    // Master clock sources
    localparam logic [1:0] CLK_SRC_NONE       = 2'h0;
    localparam logic [1:0] CLK_SRC_SPDIF_PLL  = 2'h1;
    localparam logic [1:0] CLK_SRC_ADC_PIN    = 2'h2;

    // Reset values
    localparam logic       RST_POWERDOWN_SW   = 1'b1;
    localparam logic       RST_POWERDOWN_HW   = 1'b0;
    localparam logic [1:0] RST_PIN_SYNC       = 2'h0;
    localparam logic [3:0] RST_MUTE_MASK      = 4'h0;
    localparam int         DAC_COUNT          = 4;

    typedef enum logic [1:0] {
        CFG_SOFTWARE = 2'b01,
        CFG_HARDWARE = 2'b10
    } control_mode_type;

endpackage

// *** rtl/hw_mode_if.sv ***
`timescale 1ns/10ps
interface hw_mode_if;
    // Configuration pins driven by the host
    logic       control_mode_pin;
    logic       dac_route_pin;
    logic       tx_route_pin;
    logic       spdif_tx_route_pin_lo;
    logic       spdif_tx_route_pin_hi;
    logic       chip_select_pin;
    logic       serial_clock_pin;
    logic       serial_data_in_pin;
    logic       multifunction_pin_7;
    // Mute pin: two-way, enables active low
    logic       mute_host_o;
    logic       mute_host_oe_n;
    logic       mute_dev_o;
    logic       mute_dev_oe_n;
    // Status pins driven by the device
    logic       wire_count_select_pin;
    logic       serial_data_out_pin;
    logic       status_oe_n;

    // Resolved mute level; floating reads as low
    wire mute_level = !mute_host_oe_n ? mute_host_o :
                      !mute_dev_oe_n  ? mute_dev_o  : 1'b0;

    modport device (
        input  control_mode_pin, dac_route_pin, tx_route_pin,
        input  spdif_tx_route_pin_lo, spdif_tx_route_pin_hi,
        input  chip_select_pin, serial_clock_pin, serial_data_in_pin,
        input  multifunction_pin_7, mute_host_oe_n, mute_level,
        output mute_dev_o, mute_dev_oe_n,
        output wire_count_select_pin, serial_data_out_pin, status_oe_n
    );

    modport host (
        output control_mode_pin, dac_route_pin, tx_route_pin,
        output spdif_tx_route_pin_lo, spdif_tx_route_pin_hi,
        output chip_select_pin, serial_clock_pin, serial_data_in_pin,
        output multifunction_pin_7, mute_host_o, mute_host_oe_n,
        input  mute_dev_oe_n, mute_level,
        input  wire_count_select_pin, serial_data_out_pin, status_oe_n
    );
endinterface

// *** rtl/hw_mode_pin_config_decoder.sv ***
`timescale 1ns/10ps
// Overview of operation
// - Route pins pick DAC and primary TX sources
// - Two pins pick S/PDIF transmit source
// - Secondary port disabled in hardware mode
// - Wire select pin shows receiver unlock
// - Data out pin shows non-audio OR
// - Select and clock pins set format
// - Mute pin high mutes all DACs in hardware mode
// - Software mode mutes selected DAC only
// - Floating mute pin outputs zero flag
// - Data in pin sets TX master
// - Hardware master uses 256fs, 64 bits
// - Software mode resets powered down
// - Hardware mode powerdown follows pin 7
// - Host supplies 12MHz oscillator clock
// - Receiver on: internal 256fs, clocks out
// - Receiver off: host gives ADC clock
// - Mixed routing splits clock sources
// - Hardware slave: host drives port clocks
// - Slave clocks synchronous to S/PDIF source
// - Slave with ADC data: host clocks
// - Mode pin high selects hardware mode
module hw_mode_pin_config_decoder
    import hw_mode_pkg::*;
(
    // Clock and reset (device runs on the link clock)
    input  wire logic       link_clk_in,
    input  wire logic       rst_n_in,
    // Pins
    hw_mode_if.device       pins,
    // Receiver status from the S/PDIF receiver and DAC zero flags
    input  wire logic       rx_unlock_in,
    input  wire logic       rx_non_audio_code_in,
    input  wire logic       rx_status_bit1_in,
    input  wire logic       rx_enable_in,
    input  wire logic [3:0] dac_zero_in,
    // Software mode settings
    input  wire logic [1:0] zero_mute_select_in,
    input  wire logic       mute_pin_disable_in,
    // Decoded settings
    output logic            hardware_mode_out,
    output logic            dac_source_sel_out,
    output logic            primary_tx_source_sel_out,
    output logic [1:0]      spdif_tx_source_sel_out,
    output logic            spdif_tx_valid_out,
    output logic            secondary_port_enable_out,
    output logic [1:0]      primary_format_out,
    output logic [4:0]      primary_word_length_out,
    output logic            primary_tx_master_out,
    output logic [9:0]      primary_tx_clock_ratio_out,
    output logic [6:0]      bit_clock_ratio_sel_out,
    output logic [3:0]      dac_mute_out,
    output logic            powerdown_out,
    output logic [1:0]      converter_clock_src_out,
    output logic [1:0]      primary_clock_src_out,
    output logic            port_clocks_drive_out
);

    // Two-flop synchronisers for every pin
    localparam int NPIN = 11;
    logic [NPIN-1:0] sync_a;
    logic [NPIN-1:0] sync_b;
    logic [3:0]      zero_a;
    logic [3:0]      zero_b;
    logic [2:0]      st_a;
    logic [2:0]      st_b;

    always_ff @(posedge link_clk_in) begin
        if (!rst_n_in) begin
            sync_a <= '0;
            sync_b <= '0;
        end else begin
            sync_a <= {pins.control_mode_pin, pins.dac_route_pin, pins.tx_route_pin,
                       pins.spdif_tx_route_pin_lo, pins.spdif_tx_route_pin_hi,
                       pins.chip_select_pin, pins.serial_clock_pin,
                       pins.serial_data_in_pin, pins.multifunction_pin_7,
                       pins.mute_level, pins.mute_host_oe_n};
            sync_b <= sync_a;
        end
    end

    always_ff @(posedge link_clk_in) begin
        if (!rst_n_in) begin
            zero_a <= RST_MUTE_MASK;
            zero_b <= RST_MUTE_MASK;
            st_a   <= '0;
            st_b   <= '0;
        end else begin
            zero_a <= dac_zero_in;
            zero_b <= zero_a;
            st_a   <= {rx_unlock_in, rx_non_audio_code_in | rx_status_bit1_in, rx_enable_in};
            st_b   <= st_a;
        end
    end

    // Synchronised pin levels
    logic s_mode;
    logic s_dac_pin;
    logic s_tx_pin;
    logic s_stx_lo;
    logic s_stx_hi;
    logic s_cs;
    logic s_sclk;
    logic s_data_in;
    logic s_pd_pin;
    logic s_mute;
    logic s_mute_float;
    assign {s_mode, s_dac_pin, s_tx_pin, s_stx_lo, s_stx_hi, s_cs, s_sclk, s_data_in,
            s_pd_pin, s_mute, s_mute_float} = sync_b;

    control_mode_type mode;
    always_comb begin
        case (s_mode)
            1'b1:    mode = CFG_HARDWARE;
            default: mode = CFG_SOFTWARE;
        endcase
    end
    logic hw;
    assign hw = (mode == CFG_HARDWARE);

    function automatic logic [4:0] word_length(input logic [1:0] fmt);
        word_length = (fmt == FMT_RJ20) ? 5'h14 : 5'h18;
    endfunction

    // Routing and interface format
    always_ff @(posedge link_clk_in) begin
        if (!rst_n_in) begin
            hardware_mode_out          <= 1'b0;
            dac_source_sel_out         <= DAC_SEL_SPDIF;
            primary_tx_source_sel_out  <= PTX_SRC_SPDIF;
            spdif_tx_source_sel_out    <= STX_SRC_SPDIF;
            spdif_tx_valid_out         <= 1'b1;
            secondary_port_enable_out  <= 1'b0;
            primary_format_out         <= FMT_RJ24;
            primary_word_length_out    <= word_length(FMT_RJ24);
            primary_tx_master_out      <= 1'b0;
            primary_tx_clock_ratio_out <= MCLK_RATIO_FS;
            bit_clock_ratio_sel_out    <= BCLK_PER_FRAME;
        end else begin
            hardware_mode_out          <= hw;
            dac_source_sel_out         <= s_dac_pin ? DAC_SEL_PRIMARY : DAC_SEL_SPDIF;
            primary_tx_source_sel_out  <= s_tx_pin ? PTX_SRC_ADC : PTX_SRC_SPDIF;
            spdif_tx_source_sel_out    <= {s_stx_hi, s_stx_lo};
            spdif_tx_valid_out         <= ({s_stx_hi, s_stx_lo} != STX_SRC_NONE);
            secondary_port_enable_out  <= !hw;
            primary_format_out         <= {s_cs, s_sclk};
            primary_word_length_out    <= word_length({s_cs, s_sclk});
            primary_tx_master_out      <= s_data_in;
            primary_tx_clock_ratio_out <= MCLK_RATIO_FS;
            bit_clock_ratio_sel_out    <= BCLK_PER_FRAME;
        end
    end

    // Mute and powerdown
    always_ff @(posedge link_clk_in) begin
        if (!rst_n_in) begin
            dac_mute_out  <= RST_MUTE_MASK;
            powerdown_out <= RST_POWERDOWN_SW;
        end else begin
            if (s_mute_float || !s_mute) begin
                dac_mute_out <= RST_MUTE_MASK;
            end else if (hw) begin
                dac_mute_out <= '1;
            end else if (!mute_pin_disable_in) begin
                dac_mute_out <= 4'(1 << zero_mute_select_in);
            end else begin
                dac_mute_out <= RST_MUTE_MASK;
            end
            powerdown_out <= hw ? s_pd_pin : RST_POWERDOWN_SW;
        end
    end

    // Automatic clock routing
    always_ff @(posedge link_clk_in) begin
        if (!rst_n_in) begin
            converter_clock_src_out <= CLK_SRC_NONE;
            primary_clock_src_out   <= CLK_SRC_NONE;
            port_clocks_drive_out   <= 1'b0;
        end else begin
            if (st_b[0]) begin
                converter_clock_src_out <= CLK_SRC_SPDIF_PLL;
                primary_clock_src_out   <= (s_tx_pin && !s_dac_pin) ? CLK_SRC_ADC_PIN
                                                                    : CLK_SRC_SPDIF_PLL;
            end else begin
                converter_clock_src_out <= CLK_SRC_ADC_PIN;
                primary_clock_src_out   <= CLK_SRC_ADC_PIN;
            end
            port_clocks_drive_out <= hw && s_data_in;
        end
    end

    // Status and mute pin drivers
    always_ff @(posedge link_clk_in) begin
        if (!rst_n_in) begin
            pins.wire_count_select_pin <= 1'b1;
            pins.serial_data_out_pin   <= 1'b0;
            pins.status_oe_n           <= 1'b1;
            pins.mute_dev_o            <= 1'b0;
            pins.mute_dev_oe_n         <= 1'b1;
        end else begin
            pins.wire_count_select_pin <= st_b[2];
            pins.serial_data_out_pin   <= st_b[1];
            pins.status_oe_n           <= !hw;
            pins.mute_dev_o            <= &zero_b;
            pins.mute_dev_oe_n         <= !s_mute_float;
        end
    end

endmodule // hw_mode_pin_config_decoder

// *** rtl/hw_mode_pin_host.sv ***
`timescale 1ns/10ps
module hw_mode_pin_host
    import hw_mode_pkg::*;
(
    // Clock and reset
    input  wire logic       sys_clk_in,
    input  wire logic       rst_n_in,
    // User settings
    input  wire logic       hardware_mode_in,
    input  wire logic       dac_route_in,
    input  wire logic       tx_route_in,
    input  wire logic [1:0] spdif_tx_route_in,
    input  wire logic [1:0] format_in,
    input  wire logic       tx_master_in,
    input  wire logic       powerdown_in,
    input  wire logic       mute_in,
    input  wire logic       mute_float_in,
    // Link clock out and status seen
    output logic            link_clk_out,
    output logic            unlock_out,
    output logic            non_audio_out,
    output logic            zero_flag_out,
    // Pins
    hw_mode_if.host         pins
);

    // Status pins, mute level and their drive enable, synchronised from the link domain
    logic [3:0] st_a;
    logic [3:0] st_b;

    // Link clock is sys_clk divided by two
    always_ff @(posedge sys_clk_in) begin
        if (!rst_n_in) begin
            link_clk_out <= 1'b0;
        end else begin
            link_clk_out <= !link_clk_out;
        end
    end

    always_ff @(posedge sys_clk_in) begin
        if (!rst_n_in) begin
            pins.control_mode_pin      <= 1'b0;
            pins.dac_route_pin         <= 1'b0;
            pins.tx_route_pin          <= 1'b0;
            pins.spdif_tx_route_pin_lo <= 1'b0;
            pins.spdif_tx_route_pin_hi <= 1'b0;
            pins.chip_select_pin       <= 1'b0;
            pins.serial_clock_pin      <= 1'b0;
            pins.serial_data_in_pin    <= 1'b0;
            pins.multifunction_pin_7   <= 1'b0;
            pins.mute_host_o           <= 1'b0;
            pins.mute_host_oe_n        <= 1'b0;
        end else begin
            pins.control_mode_pin      <= hardware_mode_in;
            pins.dac_route_pin         <= dac_route_in;
            pins.tx_route_pin          <= tx_route_in;
            pins.spdif_tx_route_pin_lo <= spdif_tx_route_in[0];
            pins.spdif_tx_route_pin_hi <= spdif_tx_route_in[1];
            pins.chip_select_pin       <= format_in[1];
            pins.serial_clock_pin      <= format_in[0];
            pins.serial_data_in_pin    <= tx_master_in;
            pins.multifunction_pin_7   <= powerdown_in;
            pins.mute_host_o           <= mute_in;
            pins.mute_host_oe_n        <= mute_float_in;
        end
    end

    always_ff @(posedge sys_clk_in) begin
        if (!rst_n_in) begin
            st_a          <= '0;
            st_b          <= '0;
            unlock_out    <= 1'b0;
            non_audio_out <= 1'b0;
            zero_flag_out <= 1'b0;
        end else begin
            st_a          <= {pins.wire_count_select_pin, pins.serial_data_out_pin,
                              pins.mute_level, pins.status_oe_n};
            st_b          <= st_a;
            unlock_out    <= st_b[3] && !st_b[0];
            non_audio_out <= st_b[2] && !st_b[0];
            zero_flag_out <= st_b[1] && mute_float_in;
        end
    end

endmodule // hw_mode_pin_host

// *** sim/hw_mode_properties.sv ***
`timescale 1ns/10ps
module hw_mode_properties (
    // Link domain
    input  wire logic link_clk_in,
    input  wire logic rst_n_in,
    // Interface pins
    input  wire logic control_mode_pin,
    input  wire logic mute_host_oe_n,
    input  wire logic mute_dev_oe_n,
    input  wire logic mute_dev_o,
    input  wire logic mute_level,
    input  wire logic status_oe_n
);
    default clocking @(posedge link_clk_in); endclocking
    default disable iff (!rst_n_in);

    a_status_hw_drive: assert property (control_mode_pin [*6] |-> !status_oe_n)
        else $error("status pins not driven in hardware mode");
    a_status_sw_off: assert property (!control_mode_pin [*6] |-> status_oe_n)
        else $error("status pins driven in software mode");
    a_mute_float_drive: assert property (mute_host_oe_n [*6] |-> !mute_dev_oe_n)
        else $error("floating mute pin not driven with zero flag");
    a_mute_yield_host: assert property (!mute_host_oe_n [*6] |-> mute_dev_oe_n)
        else $error("device drives mute pin while host drives it");
    a_status_rise_cause: assert property ($rose(status_oe_n) |->
        !$past(control_mode_pin, 2) || !$past(control_mode_pin, 3)
        || !$past(control_mode_pin, 4))
        else $error("status release without mode pin low");
    a_status_fall_cause: assert property ($fell(status_oe_n) |->
        $past(control_mode_pin, 2) || $past(control_mode_pin, 3)
        || $past(control_mode_pin, 4))
        else $error("status drive without mode pin high");
    a_mute_drive_cause: assert property ($fell(mute_dev_oe_n) |->
        $past(mute_host_oe_n, 2) || $past(mute_host_oe_n, 3) || $past(mute_host_oe_n, 4))
        else $error("mute pin driven without host floating it");
    a_mute_level_dev: assert property (!mute_dev_oe_n && mute_host_oe_n |->
        mute_level == mute_dev_o)
        else $error("mute level differs from device drive");

    c_status_hw: cover property ($fell(status_oe_n));
    c_zero_flag: cover property (!mute_dev_oe_n && mute_level);
    c_host_mute: cover property (!mute_host_oe_n && control_mode_pin);
endmodule // hw_mode_properties

// *** sim/tb_top.sv ***
`timescale 1ns/10ps
module tb_top;
    import hw_mode_pkg::*;
    // Clocks, reset and counters
    logic       sys_clk;
    logic       rst_n = 1'b0;
    // The link clock only runs once the host is out of reset
    logic       link_rst_n = 1'b0;
    logic       link_clk;
    int         err_count = 0;
    int         checks_done = 0;
    // Host user side
    logic       hw = 1'b0, dac_r = 1'b0, tx_r = 1'b0, ms = 1'b0;
    logic       pd = 1'b0, mute = 1'b0, flt = 1'b0;
    logic [1:0] sp_r = 2'h0, fmt = 2'h0;
    logic       unlock_seen, non_audio_seen, zero_seen;
    // Device side inputs and outputs
    logic       rx_unlock = 1'b0, rx_code = 1'b0, rx_bit1 = 1'b0, rx_en = 1'b0;
    logic       mute_dis = 1'b0;
    logic [3:0] dac_zero = 4'h0;
    logic [1:0] zsel = 2'h0;
    logic       hw_o, dac_source_sel, ptx_src, stx_valid, sec_en, ptx_ms, pwr_dn, clk_drv;
    logic [1:0] stx_src, fmt_o, conv_src, prim_src;
    logic [4:0] wl;
    logic [9:0] ratio;
    logic [6:0] bratio;
    logic [3:0] dmute;

    hw_mode_if pins_if ();

    hw_mode_pin_host hw_mode_pin_host_i (.sys_clk_in(sys_clk), .rst_n_in(rst_n),
        .hardware_mode_in(hw), .dac_route_in(dac_r), .tx_route_in(tx_r),
        .spdif_tx_route_in(sp_r), .format_in(fmt), .tx_master_in(ms), .powerdown_in(pd),
        .mute_in(mute), .mute_float_in(flt), .link_clk_out(link_clk),
        .unlock_out(unlock_seen), .non_audio_out(non_audio_seen),
        .zero_flag_out(zero_seen), .pins(pins_if.host));

    hw_mode_pin_config_decoder hw_mode_pin_config_decoder_i (.link_clk_in(link_clk),
        .rst_n_in(link_rst_n), .pins(pins_if.device), .rx_unlock_in(rx_unlock),
        .rx_non_audio_code_in(rx_code), .rx_status_bit1_in(rx_bit1), .rx_enable_in(rx_en),
        .dac_zero_in(dac_zero), .zero_mute_select_in(zsel), .mute_pin_disable_in(mute_dis),
        .hardware_mode_out(hw_o), .dac_source_sel_out(dac_source_sel),
        .primary_tx_source_sel_out(ptx_src), .spdif_tx_source_sel_out(stx_src),
        .spdif_tx_valid_out(stx_valid), .secondary_port_enable_out(sec_en),
        .primary_format_out(fmt_o), .primary_word_length_out(wl),
        .primary_tx_master_out(ptx_ms), .primary_tx_clock_ratio_out(ratio),
        .bit_clock_ratio_sel_out(bratio), .dac_mute_out(dmute), .powerdown_out(pwr_dn),
        .converter_clock_src_out(conv_src), .primary_clock_src_out(prim_src),
        .port_clocks_drive_out(clk_drv));

    hw_mode_properties hw_mode_properties_i (.link_clk_in(link_clk), .rst_n_in(link_rst_n),
        .control_mode_pin(pins_if.control_mode_pin), .mute_host_oe_n(pins_if.mute_host_oe_n),
        .mute_dev_oe_n(pins_if.mute_dev_oe_n), .mute_dev_o(pins_if.mute_dev_o),
        .mute_level(pins_if.mute_level), .status_oe_n(pins_if.status_oe_n));

    initial begin
        sys_clk = 1'b0;
        forever #20 sys_clk = ~sys_clk;
    end

    task automatic chk(input string what, input logic [9:0] seen, input logic [9:0] exp);
        checks_done++;
        if (seen !== exp) begin
            err_count++;
            $display("CHECK FAILED %s expected %0h seen %0h", what, exp, seen);
        end
    endtask

    // Covers both synchronisers and the output register of either end
    task automatic settle();
        repeat (24) @(negedge sys_clk);
    endtask

    task automatic t_power();
        hw = 1'b0;
        settle();
        chk("powerdown_sw", pwr_dn, 10'h1);
        chk("secondary_sw", sec_en, 10'h1);
        chk("status_oe_sw", pins_if.status_oe_n, 10'h1);
        chk("hw_mode_sw", hw_o, 10'h0);
        hw = 1'b1;
        pd = 1'b0;
        settle();
        chk("powerdown_lo", pwr_dn, 10'h0);
        pd = 1'b1;
        settle();
        chk("powerdown_hi", pwr_dn, 10'h1);
        pd = 1'b0;
    endtask

    task automatic t_routing();
        hw = 1'b1;
        rx_en = 1'b1;
        for (int i = 0; i < 16; i++) begin
            {sp_r, tx_r, dac_r} = i[3:0];
            fmt = i[1:0] ^ i[3:2];
            ms = i[2];
            settle();
            chk("hw_mode", hw_o, 10'h1);
            chk("dac_source_sel", dac_source_sel, i[0]);
            chk("ptx_src", ptx_src, i[1]);
            chk("stx_src", stx_src, i[3:2]);
            chk("stx_valid", stx_valid, i[3:2] != 2'h2);
            chk("secondary", sec_en, 10'h0);
            chk("format", fmt_o, fmt);
            chk("word_len", wl, (fmt == FMT_RJ20) ? 10'h14 : 10'h18);
            chk("tx_master", ptx_ms, ms);
            chk("mclk_ratio", ratio, 10'h100);
            chk("bclk_ratio", bratio, 10'h40);
            chk("conv_clk", conv_src, CLK_SRC_SPDIF_PLL);
            chk("prim_clk", prim_src, (tx_r && !dac_r) ? CLK_SRC_ADC_PIN : CLK_SRC_SPDIF_PLL);
            chk("clk_drive", clk_drv, ms);
        end
        rx_en = 1'b0;
        settle();
        chk("conv_clk_off", conv_src, CLK_SRC_ADC_PIN);
        chk("prim_clk_off", prim_src, CLK_SRC_ADC_PIN);
    endtask

    task automatic t_status();
        hw = 1'b1;
        for (int j = 0; j < 8; j++) begin
            {rx_unlock, rx_code, rx_bit1} = j[2:0];
            settle();
            chk("unlock_pin", pins_if.wire_count_select_pin, j[2]);
            chk("non_audio_pin", pins_if.serial_data_out_pin, j[1] | j[0]);
            chk("status_oe", pins_if.status_oe_n, 10'h0);
            chk("unlock_host", unlock_seen, j[2]);
            chk("non_audio_host", non_audio_seen, j[1] | j[0]);
        end
    endtask

    task automatic t_mute();
        hw = 1'b1;
        mute = 1'b1;
        settle();
        chk("mute_all", dmute, 10'hF);
        mute = 1'b0;
        settle();
        chk("mute_none", dmute, 10'h0);
        hw = 1'b0;
        mute = 1'b1;
        for (int k = 0; k < 4; k++) begin
            zsel = k[1:0];
            settle();
            chk("mute_one", dmute, 10'h1 << k);
        end
        mute_dis = 1'b1;
        settle();
        chk("mute_disabled", dmute, 10'h0);
        flt = 1'b1;
        dac_zero = 4'hF;
        settle();
        chk("zero_flag_set", zero_seen, 10'h1);
        chk("zero_level", pins_if.mute_level, 10'h1);
        dac_zero = 4'h7;
        settle();
        chk("zero_flag_clr", zero_seen, 10'h0);
        flt = 1'b0;
        mute = 1'b0;
        mute_dis = 1'b0;
    endtask

    task automatic close_out();
        $display("Checks %0d, mismatches %0d", checks_done, err_count);
        if (err_count == 0 && checks_done > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    initial begin
        repeat (8) @(negedge sys_clk);
        rst_n = 1'b1;
        repeat (8) @(negedge sys_clk);
        link_rst_n = 1'b1;
        repeat (4) @(negedge sys_clk);
        t_power();
        t_routing();
        t_status();
        t_mute();
        close_out();
    end

    initial begin
        repeat (4000) @(posedge sys_clk);
        err_count++;
        close_out();
    end
endmodule // tb_top
